/* File: sfs_defs.vh */
// Constants for the flow-through burst SRAM pin control block
`ifndef SFS_DEFS_VH
`define SFS_DEFS_VH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SFS_ADDR_W      18
`define SFS_DQ_W        16
`define SFS_DP_W        2
`define SFS_WORD_W      18
`define SFS_LANE_N      2
`define SFS_LANE_BITS   8
`define SFS_BURST_W     2
`define SFS_ENTRY_W     38

// ----------------------------------------------------------------
// Write buffer shape
// ----------------------------------------------------------------
`define SFS_FIFO_DEPTH  8
`define SFS_FIFO_AW     3

// ----------------------------------------------------------------
// Operation states, one-hot
// ----------------------------------------------------------------
`define SFS_ST_IDLE     3'h1
`define SFS_ST_READ     3'h2
`define SFS_ST_WRITE    3'h4

// ----------------------------------------------------------------
// Reset values and burst increment
// ----------------------------------------------------------------
`define SFS_STRAP_RST   1'b1
`define SFS_LANES_OFF   2'h3
`define SFS_BURST_ZERO  2'h0
`define SFS_BURST_ONE   2'h1
`define SFS_ADDR_ZERO   18'h00000
`define SFS_WORD_ZERO   18'h00000

`endif

/* File: sfs_master_pins.sv */
// Bus master pin model: shared data wires and burst-order strap
`timescale 1ns/1ps
`include "sfs_defs.vh"
module sfs_master_pins (
    input  wire                   clk_sys,
    input  wire                   reset_n,
    input  wire                   mode_sel,
    input  wire                   drv_en,
    input  wire [`SFS_WORD_W-1:0] drv_word,
    input  wire                   data_oe,
    input  wire                   parity_lines_oe,
    input  wire [`SFS_DQ_W-1:0]   data_out,
    input  wire [`SFS_DP_W-1:0]   parity_lines_out,
    output wire [`SFS_DQ_W-1:0]   data_in,
    output wire [`SFS_DP_W-1:0]   parity_lines_in,
    output reg                    burst_order_strap,
    output wire                   clash
);
    reg [`SFS_WORD_W-1:0] last_reg = 18'h00000;
    // Wire level: master write data, device read data, else drifting
    assign data_in = drv_en ? drv_word[15:0] : data_oe ? data_out : ~last_reg[15:0];
    assign parity_lines_in = drv_en ? drv_word[17:16] :
        parity_lines_oe ? parity_lines_out : ~last_reg[17:16];
    assign clash = drv_en && (data_oe || parity_lines_oe);
    // Remember last wire level
    always @(posedge clk_sys) begin
        last_reg <= {parity_lines_in, data_in};
    end
    // Strap only moves while reset holds the device
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            burst_order_strap <= mode_sel;
        end
    end
endmodule

/* File: sfs_sram_ctrl.v */
// Pin-side control, burst sequencing, write buffer and array of the SRAM
`timescale 1ns/1ps
`include "sfs_defs.vh"

// ----------------------------------------------------------------
// Write posting buffer
// ----------------------------------------------------------------
module sfs_fifo #(
    parameter WIDTH = `SFS_ENTRY_W,
    parameter DEPTH = `SFS_FIFO_DEPTH,
    parameter AW    = `SFS_FIFO_AW
) (
    input  wire                   clk_sys,
    input  wire                   reset_n,
    input  wire                   in_valid,
    output wire                   in_ready,
    input  wire [WIDTH-1:0]       in_data,
    output wire                   out_valid,
    input  wire                   out_ready,
    output wire [WIDTH-1:0]       out_data,
    output wire [WIDTH*DEPTH-1:0] store_flat,
    output wire [AW-1:0]          head_ptr,
    output wire [AW:0]            fill_count
);
    reg  [WIDTH-1:0] store [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_reg;
    reg  [AW-1:0]    rd_ptr_reg;
    reg  [AW:0]      count_reg;
    wire             push;
    wire             pop;
    genvar           g;

    // Honest full and empty from the occupancy count
    assign in_ready   = (count_reg != DEPTH[AW:0]);
    assign out_valid  = (count_reg != {(AW+1){1'b0}});
    assign push       = in_valid & in_ready;
    assign pop        = out_valid & out_ready;
    assign out_data   = store[rd_ptr_reg];
    assign head_ptr   = rd_ptr_reg;
    assign fill_count = count_reg;

    // Expose contents for read forwarding
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_flat
            assign store_flat[g*WIDTH +: WIDTH] = store[g];
        end
    endgenerate

    // Entry storage
    always @(posedge clk_sys) begin
        if (push) begin
            store[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and count
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, push};
            rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, pop};
            count_reg  <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// Functional notes
// - Selected only with selects low, high, low
// - Output gate high forces data pins undriven
// - Qualifier high ignores edge, holds all state except the first strap capture after reset
// - Data lines captured on rising edge
// - Read data from address of preceding edge
// - Undriven on write data, emerge, deselect
// - Parity lines follow data, gated per lane
// - Strap high interleaved, low linear order
// - Unconnected strap behaves as interleaved; here the strap resets high, then the first edge after reset loads the pin
// - Burst uses two low bits, wraps four
// - Write data taken edge after command
module sfs_sram_ctrl #(
    parameter ADDR_W     = `SFS_ADDR_W,
    parameter FIFO_DEPTH = `SFS_FIFO_DEPTH,
    parameter FIFO_AW    = `SFS_FIFO_AW
) (
    input  wire                  clk_sys,
    input  wire                  reset_n,
    input  wire                  clock_qualifier_n,
    input  wire                  chip_select_low_a,
    input  wire                  chip_select_high,
    input  wire                  chip_select_low_b,
    input  wire                  output_gate_n,
    input  wire                  write_n,
    input  wire                  advance_or_load,
    input  wire [`SFS_LANE_N-1:0] byte_lane_select_n,
    input  wire [ADDR_W-1:0]     addr,
    input  wire [`SFS_DQ_W-1:0]  data_in,
    output wire [`SFS_DQ_W-1:0]  data_out,
    output wire                  data_oe,
    input  wire [`SFS_DP_W-1:0]  parity_lines_in,
    output wire [`SFS_DP_W-1:0]  parity_lines_out,
    output wire                  parity_lines_oe,
    input  wire                  burst_order_strap,
    output wire                  write_buffer_ready
);
    localparam EW       = ADDR_W + `SFS_LANE_N + `SFS_WORD_W;
    localparam ST_IDLE  = `SFS_ST_IDLE;
    localparam ST_READ  = `SFS_ST_READ;
    localparam ST_WRITE = `SFS_ST_WRITE;

    reg  [`SFS_WORD_W-1:0]   mem [0:(1<<ADDR_W)-1];
    reg  [2:0]               state_reg;
    reg  [2:0]               state_next;
    reg  [ADDR_W-1:0]        base_reg;
    reg  [ADDR_W-1:0]        base_next;
    reg  [`SFS_BURST_W-1:0]  cnt_reg;
    reg  [`SFS_BURST_W-1:0]  cnt_next;
    reg  [`SFS_LANE_N-1:0]   lanes_reg;
    reg  [`SFS_LANE_N-1:0]   lanes_next;
    reg  [`SFS_WORD_W-1:0]   rd_data_reg;
    reg  [`SFS_WORD_W-1:0]   fwd_word;
    reg                      emerge_reg;
    reg                      strap_reg;
    reg                      strap_caught_reg;
    reg  [`SFS_BURST_W-1:0]  low_bits;
    reg  [ADDR_W-1:0]        acc_addr;
    reg  [EW-1:0]            entry;
    reg  [FIFO_AW-1:0]       idx;
    integer                  k;
    wire                     edge_ok;
    wire                     selected;
    wire [ADDR_W-1:0]        cur_addr;
    wire                     enq_valid;
    wire [EW-1:0]            enq_data;
    wire                     drain_valid;
    wire                     drain_ready;
    wire [EW-1:0]            drain_data;
    wire [EW*FIFO_DEPTH-1:0] fifo_flat;
    wire [FIFO_AW-1:0]       fifo_head;
    wire [FIFO_AW:0]         fifo_count;
    wire [ADDR_W-1:0]        drain_addr;
    wire [`SFS_WORD_W-1:0]   drain_mask;
    wire [`SFS_WORD_W-1:0]   drain_word;

    // Byte lane mask over data and parity bits
    function [`SFS_WORD_W-1:0] lane_mask;
        input [`SFS_LANE_N-1:0] sel_n;
        integer l;
        begin
            lane_mask = `SFS_WORD_ZERO;
            for (l = 0; l < `SFS_LANE_N; l = l + 1) begin
                if (!sel_n[l]) begin
                    lane_mask[l*`SFS_LANE_BITS +: `SFS_LANE_BITS] = {`SFS_LANE_BITS{1'b1}};
                    lane_mask[`SFS_DQ_W + l] = 1'b1;
                end
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Selection and burst sequencing
    // ----------------------------------------------------------------
    assign edge_ok  = ~clock_qualifier_n;
    assign selected = ~chip_select_low_a & chip_select_high & ~chip_select_low_b;

    // Next operation, base and burst count
    always @* begin
        state_next = state_reg;
        base_next  = base_reg;
        cnt_next   = cnt_reg;
        lanes_next = lanes_reg;
        if (edge_ok) begin
            lanes_next = byte_lane_select_n;
            if (!advance_or_load) begin
                cnt_next = `SFS_BURST_ZERO;
                if (selected) begin
                    base_next  = addr;
                    state_next = write_n ? ST_READ : ST_WRITE;
                end else begin
                    state_next = ST_IDLE;
                end
            end else begin
                cnt_next = cnt_reg + `SFS_BURST_ONE;
            end
        end
    end

    // Burst address from base and count
    always @* begin
        low_bits = strap_reg ? (base_next[`SFS_BURST_W-1:0] ^ cnt_next)
                             : (base_next[`SFS_BURST_W-1:0] + cnt_next);
        acc_addr = {base_next[ADDR_W-1:`SFS_BURST_W], low_bits};
    end

    assign cur_addr = {base_reg[ADDR_W-1:`SFS_BURST_W],
                       strap_reg ? (base_reg[`SFS_BURST_W-1:0] ^ cnt_reg)
                                 : (base_reg[`SFS_BURST_W-1:0] + cnt_reg)};

    // ----------------------------------------------------------------
    // Write path through the posting buffer
    // ----------------------------------------------------------------
    assign enq_valid   = edge_ok & (state_reg == ST_WRITE);
    assign enq_data    = {cur_addr, lanes_reg, parity_lines_in, data_in};
    assign drain_ready = edge_ok & (state_next != ST_READ);
    assign drain_addr  = drain_data[EW-1 -: ADDR_W];
    assign drain_mask  = lane_mask(drain_data[`SFS_WORD_W +: `SFS_LANE_N]);
    assign drain_word  = drain_data[`SFS_WORD_W-1:0];
    assign write_buffer_ready = drain_ready | (fifo_count != FIFO_DEPTH[FIFO_AW:0]);

    sfs_fifo #(
        .WIDTH (EW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_wbuf (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .in_valid   (enq_valid),
        .in_ready   (),
        .in_data    (enq_data),
        .out_valid  (drain_valid),
        .out_ready  (drain_ready),
        .out_data   (drain_data),
        .store_flat (fifo_flat),
        .head_ptr   (fifo_head),
        .fill_count (fifo_count)
    );

    // Array update with byte lanes
    always @(posedge clk_sys) begin
        if (drain_valid && drain_ready) begin
            mem[drain_addr] <= (mem[drain_addr] & ~drain_mask) | (drain_word & drain_mask);
        end
    end

    // Read word merged with posted and incoming writes, oldest first
    always @* begin
        entry    = {EW{1'b0}};
        idx      = {FIFO_AW{1'b0}};
        fwd_word = mem[acc_addr];
        for (k = 0; k < FIFO_DEPTH; k = k + 1) begin
            idx   = fifo_head + k[FIFO_AW-1:0];
            entry = fifo_flat[idx*EW +: EW];
            if ((k < fifo_count) && (entry[EW-1 -: ADDR_W] == acc_addr)) begin
                fwd_word = (fwd_word & ~lane_mask(entry[`SFS_WORD_W +: `SFS_LANE_N]))
                         | (entry[`SFS_WORD_W-1:0] & lane_mask(entry[`SFS_WORD_W +: `SFS_LANE_N]));
            end
        end
        if (enq_valid && (cur_addr == acc_addr)) begin
            fwd_word = (fwd_word & ~lane_mask(lanes_reg))
                     | ({parity_lines_in, data_in} & lane_mask(lanes_reg));
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Operation state, burst, read data and strap capture
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg        <= ST_IDLE;
            base_reg         <= `SFS_ADDR_ZERO;
            cnt_reg          <= `SFS_BURST_ZERO;
            lanes_reg        <= `SFS_LANES_OFF;
            rd_data_reg      <= `SFS_WORD_ZERO;
            emerge_reg       <= 1'b0;
            strap_reg        <= `SFS_STRAP_RST;
            strap_caught_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            base_reg  <= base_next;
            cnt_reg   <= cnt_next;
            lanes_reg <= lanes_next;
            if (!strap_caught_reg) begin
                strap_reg        <= burst_order_strap;
                strap_caught_reg <= 1'b1;
            end
            if (edge_ok) begin
                emerge_reg <= (state_reg == ST_IDLE) && (state_next != ST_IDLE);
                if (state_next == ST_READ) begin
                    rd_data_reg <= fwd_word;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    // Drive only in a read data phase with the gate low
    assign data_oe          = (state_reg == ST_READ) & ~emerge_reg & ~output_gate_n;
    assign parity_lines_oe  = data_oe;
    assign data_out         = rd_data_reg[`SFS_DQ_W-1:0];
    assign parity_lines_out = rd_data_reg[`SFS_WORD_W-1:`SFS_DQ_W];
endmodule

/* File: sfs_sram_ctrl_checker.sv */
// Concurrent checks on the SRAM pin control ports
`timescale 1ns/1ps
`include "sfs_defs.vh"
module sfs_sram_checker (
    input wire                 clk_sys,
    input wire                 reset_n,
    input wire                 clock_qualifier_n,
    input wire                 chip_select_low_a,
    input wire                 chip_select_high,
    input wire                 chip_select_low_b,
    input wire                 output_gate_n,
    input wire                 write_n,
    input wire                 advance_or_load,
    input wire [`SFS_DQ_W-1:0] data_out,
    input wire                 data_oe,
    input wire [`SFS_DP_W-1:0] parity_lines_out,
    input wire                 parity_lines_oe
);
    wire sel_w = !chip_select_low_a && chip_select_high && !chip_select_low_b;
    wire go_w  = !clock_qualifier_n;
    wire ld_w  = go_w && !advance_or_load;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_gate_blocks_oe: assert property (data_oe |-> !output_gate_n)
        else $error("pins driven while gate high");
    a_parity_follows: assert property (parity_lines_oe == data_oe)
        else $error("parity drive differs from data drive");
    a_write_quiet: assert property (ld_w && sel_w && !write_n |=> !data_oe)
        else $error("pins driven in write data cycle");
    a_deselect_quiet: assert property (ld_w && !sel_w |=> !data_oe)
        else $error("pins driven while deselected");
    a_stall_data: assert property (clock_qualifier_n |=> $stable(data_out)
        && $stable(parity_lines_out)) else $error("read data moved on ignored edge");
    a_stall_oe: assert property (clock_qualifier_n |=> $stable(data_oe)
        || !$stable(output_gate_n)) else $error("drive moved on ignored edge");
    a_read_drives: assert property ((ld_w && sel_w && write_n) ##1
        (ld_w && sel_w && write_n) |=> (data_oe || output_gate_n))
        else $error("second read not driven");
    a_burst_wr_quiet: assert property ((ld_w && sel_w && !write_n) ##1
        (go_w && advance_or_load) |=> !data_oe) else $error("burst write driven");
    a_burst_rd_drives: assert property ((ld_w && sel_w && write_n) ##1
        (go_w && advance_or_load) |=> (data_oe || output_gate_n))
        else $error("burst read not driven");
endmodule

bind sfs_sram_ctrl sfs_sram_checker i_chk (.clk_sys, .reset_n, .clock_qualifier_n,
    .chip_select_low_a, .chip_select_high, .chip_select_low_b, .output_gate_n, .write_n,
    .advance_or_load, .data_out, .data_oe, .parity_lines_out, .parity_lines_oe);

/* File: sfs_sram_ctrl_test.sv */
// Self-checking bench for the SRAM pin control block
`timescale 1ns/1ps
`include "sfs_defs.vh"
module sfs_sram_ctrl_test;
    reg         clk_sys = 1'b0;
    reg         reset_n = 1'b0;
    reg         clock_qualifier_n, output_gate_n, write_n, advance_or_load, mode_sel, drv_en;
    reg  [2:0]  cs_pins;
    reg  [1:0]  byte_lane_select_n;
    reg  [17:0] addr, drv_word;
    wire [15:0] data_in, data_out;
    wire [1:0]  parity_lines_in, parity_lines_out;
    wire        data_oe, parity_lines_oe, burst_order_strap, clash, write_buffer_ready;
    int         err_total = 0;
    int         n_checks = 0;
    int         i;
    logic [17:0] ref_mem [0:262143];
    logic [17:0] exp_q [$];
    logic [17:0] ta [4];
    logic [17:0] base, pend_a, ea, rd_v;
    logic [1:0]  cnt, pend_ln;
    bit          sel_s, wr_s, pend, gate_v, mode, rd_p;

    sfs_sram_ctrl i_dut (.clk_sys, .reset_n, .clock_qualifier_n, .chip_select_low_a(cs_pins[2]),
        .chip_select_high(cs_pins[1]), .chip_select_low_b(cs_pins[0]), .output_gate_n,
        .write_n, .advance_or_load, .byte_lane_select_n, .addr, .data_in, .data_out,
        .data_oe, .parity_lines_in, .parity_lines_out, .parity_lines_oe,
        .burst_order_strap, .write_buffer_ready);
    sfs_master_pins i_pins (.clk_sys, .reset_n, .mode_sel, .drv_en, .drv_word, .data_oe,
        .parity_lines_oe, .data_out, .parity_lines_out, .data_in, .parity_lines_in,
        .burst_order_strap, .clash);

    // Clock
    always #12.5 clk_sys = ~clk_sys;

    task bad(input string m);
        err_total++;
        $display("Error at %0t: %s", $time, m);
    endtask

    task final_report;
        if (exp_q.size() != 0) bad("read results missing");
        if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // One recognized edge: new command plus data for the previous write
    task op(input bit ld, input bit w, input [2:0] cs, input [17:0] a, input [1:0] ln);
        logic [17:0] wd;
        bit          was;
        wd = 18'($urandom);
        was = sel_s;
        @(posedge clk_sys);
        clock_qualifier_n <= 1'b0;
        // Previous read shows in this cycle, under this cycle's gate
        if (rd_p && !gate_v) exp_q.push_back(rd_v);
        advance_or_load <= !ld;
        write_n <= !w;
        cs_pins <= cs;
        addr <= a;
        byte_lane_select_n <= ln;
        output_gate_n <= gate_v;
        drv_en <= pend;
        drv_word <= wd;
        if (pend && !pend_ln[0]) {ref_mem[pend_a][16], ref_mem[pend_a][7:0]} = {wd[16], wd[7:0]};
        if (pend && !pend_ln[1]) {ref_mem[pend_a][17], ref_mem[pend_a][15:8]} = {wd[17], wd[15:8]};
        if (ld) {sel_s, wr_s, base, cnt} = {cs == 3'h2, w, a, 2'h0};
        else cnt = cnt + 2'h1;
        ea = {base[17:2], mode ? base[1:0] ^ cnt : base[1:0] + cnt};
        {pend, pend_a, pend_ln} = {sel_s && wr_s, ea, ln};
        {rd_p, rd_v} = {sel_s && !wr_s && was, ref_mem[ea]};
    endtask

    task burst(input bit w, input [17:0] a, input int n);
        op(1'b1, w, 3'h2, a, 2'h0);
        repeat (n) op(1'b0, w, 3'h7, 18'($urandom), 2'h0);
    endtask

    // Ignored edges with select, command, lane and address inputs wandering
    task stall(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            clock_qualifier_n <= 1'b1;
            {cs_pins, write_n, advance_or_load, byte_lane_select_n} <= 7'($urandom);
            addr <= 18'($urandom);
        end
    endtask

    task rst(input bit m);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        mode_sel <= m;
        drv_en <= 1'b0;
        mode = m;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        {sel_s, pend, rd_p} = 3'h0;
    endtask

    // Result watcher: oldest note against each driven cycle on a recognized edge
    always @(posedge clk_sys) begin
        if (reset_n && !clock_qualifier_n && data_oe === 1'b1) begin
            n_checks++;
            if (exp_q.size() == 0) bad("pins driven unexpectedly");
            else if ({parity_lines_out, data_out} !== exp_q.pop_front()) bad("read data");
        end
        if (clash === 1'b1) bad("bus clash");
    end

    // Main sequence
    initial begin
        {clock_qualifier_n, write_n, advance_or_load, output_gate_n, drv_en} = 5'h06;
        {cs_pins, byte_lane_select_n, addr, drv_word, mode_sel, gate_v} = 0;
        void'($urandom(32'he8d541d8));
        rst(1'b1);
        op(1'b1, 1'b0, 3'h7, 18'h00000, 2'h0);
        op(1'b1, 1'b0, 3'h2, 18'h00001, 2'h0);
        for (i = 0; i < 4; i++) begin
            ta[i] = 18'($urandom);
            op(1'b1, 1'b1, 3'h2, ta[i], 2'h0);
        end
        for (i = 0; i < 4; i++) op(1'b1, 1'b0, 3'h2, ta[i], 2'h0);
        for (i = 0; i < 4; i++) begin
            op(1'b1, 1'b1, 3'h2, ta[i], i[1:0]);
            op(1'b1, 1'b0, 3'h2, ta[i], 2'h0);
        end
        for (i = 0; i < 8; i++) op(1'b1, 1'b1, i[2:0], ta[0], 2'h0);
        for (i = 0; i < 2; i++) op(1'b1, 1'b0, 3'h2, ta[0], 2'h0);
        burst(1'b1, ta[1], 3);
        burst(1'b0, ta[1], 4);
        op(1'b1, 1'b0, 3'h2, ta[2], 2'h0);
        stall(3);
        op(1'b1, 1'b0, 3'h2, ta[3], 2'h0);
        gate_v = 1'b1;
        op(1'b1, 1'b0, 3'h2, ta[2], 2'h0);
        op(1'b1, 1'b1, 3'h2, ta[3], 2'h0);
        gate_v = 1'b0;
        op(1'b1, 1'b0, 3'h2, ta[3], 2'h0);
        for (i = 0; i < 2; i++) op(1'b1, 1'b0, 3'h7, 18'h00000, 2'h0);
        rst(1'b0);
        burst(1'b1, ta[2], 3);
        burst(1'b0, ta[2], 4);
        for (i = 0; i < 2; i++) op(1'b1, 1'b0, 3'h7, 18'h00000, 2'h0);
        @(negedge clk_sys);
        n_checks++;
        if (write_buffer_ready !== 1'b1) bad("write buffer refused");
        final_report;
    end
endmodule
